//--- design/status_word_flag_logic.sv
// Overview of operation
// - Priority field in bits 7-5, full load.
// - Bit 4 trace, loaded from multiplexer bit 4.
// - Bit 3 set for negative result.
// - Bit 2 set for zero result.
// - Bit 1 set on arithmetic overflow.
// - Bit 0 set on carry out.
// - Trap, interrupt, return load whole word.
// - Eight bits, flags stored apart from priority.
// - Delayed trace copy is pending trap flag.
// - Select high passes data bits 0-3.
// - Per-bit gated loads on the processor clock.
// - Power-fail init disables the flag selector.
// - Aux field bit registered picks computed flags.
// - Table gives carry/overflow; subtract modifies carry.
// - Shifts override carry and overflow sources.
// - Table inputs delayed one clock.
// - Negative and zero delayed one stage.
// - Negative chosen by byte and rotate flags.
// - Zero chosen by byte and rotate flags.
// - Select 00 rotate right up to 11 shift left.
// - ALU select lines shared with shift selectors.
// - Rotate carry is bit 15 left, 0 right.
// - Rotate negative: left sign, shift-right bit 15.
// - Right shift overflow is negative xor carry.
//
// Implementation choices: the address map and the APB interface to the registers.
module status_word_flag_logic (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [15:0] a_side_data,
    input wire logic [15:0] b_shift_register,
    input wire logic [15:0] b_operand_path,
    input wire logic left_shift_sign,
    input wire logic byte_instr_flag,
    input wire logic rotate_instr_flag,
    input wire logic alu_select_hi_n,
    input wire logic alu_select_lo_n,
    input wire logic aux_field_n,
    input wire logic full_status_load_n,
    input wire logic carry_clock_delayed_n,
    input wire logic powerfail_init,
    input wire logic subtract_instr,
    input wire logic [4:0] cv_table_in,
    output logic [7:0] status_word,
    output logic trace_pending_ff
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    // Flags and the priority/trace group are separate fields so that the
    // flags can be loaded on their own enables; priority/trace loads only with them.
    typedef struct packed {
        logic [2:0] priority_lvl;
        logic trace;
        logic [3:0] flags;
        logic trace_pending;
        logic aux_del_n;
        logic neg_del;
        logic zero_del;
        logic rot_c_del;
        logic rot_del;
        logic sub_del;
        logic [4:0] cv_del;
        logic apb_ready;
        logic apb_err;
        logic [31:0] apb_rdata;
    } state_t;

    state_t s_q;
    state_t s_d;

    logic next_negative;
    logic next_zero;
    logic rotate_carry_out;
    logic rotate_negative;
    logic apb_setup;
    logic apb_access;
    logic status_wr;

    // ------------------------------------------------------------
    // Flag computation datapath
    // ------------------------------------------------------------
    shift_flag_logic u_shift_flag_logic (
        .a_side_data(a_side_data),
        .b_shift_register(b_shift_register),
        .b_operand_path(b_operand_path),
        .left_shift_sign(left_shift_sign),
        .carry_flag(s_q.flags[status_flag_pkg::CARRY_BIT]),
        .byte_instr_flag(byte_instr_flag),
        .rotate_instr_flag(rotate_instr_flag),
        .alu_select_hi_n(alu_select_hi_n),
        .alu_select_lo_n(alu_select_lo_n),
        .next_negative(next_negative),
        .next_zero(next_zero),
        .rotate_carry_out(rotate_carry_out),
        .rotate_negative(rotate_negative)
    );

    assign apb_setup = psel & ~penable;
    assign apb_access = psel & penable & s_q.apb_ready;
    assign status_wr = apb_access & pwrite & (paddr == status_flag_pkg::STATUS_WORD_ADDR);

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic [1:0] cv;
        logic c_calc;
        logic v_calc;
        logic [3:0] sel;
        logic full;
        cv = status_flag_pkg::cv_lookup(s_q.cv_del);
        c_calc = 1'b0;
        v_calc = 1'b0;
        sel = 4'h0;
        full = ~full_status_load_n;
        s_d = s_q;

        // Input pipeline: one stage before the table and the selector.
        s_d.aux_del_n = aux_field_n;
        s_d.neg_del = next_negative;
        s_d.zero_del = next_zero;
        s_d.rot_c_del = rotate_carry_out;
        s_d.rot_del = rotate_instr_flag;
        s_d.sub_del = subtract_instr;
        s_d.cv_del = cv_table_in;

        // Carry and overflow: table for arithmetic, gating for shifts.
        if (s_q.rot_del) begin
            c_calc = s_q.rot_c_del;
            v_calc = s_q.neg_del ^ s_q.rot_c_del;
        end else begin
            c_calc = cv[0] ^ s_q.sub_del;
            v_calc = cv[1];
        end

        // Flag source selector; a disabled selector drives zeros.
        if (powerfail_init) begin
            sel = 4'h0;
        end else if (s_q.aux_del_n) begin
            sel = a_side_data[3:0];
        end else begin
            sel = {s_q.neg_del, s_q.zero_del, v_calc, c_calc};
        end

        // Per-bit gated loads.
        if (full) begin
            s_d.priority_lvl = a_side_data[7:5];
            s_d.trace = a_side_data[4];
            s_d.flags = sel;
        end else begin
            if (!s_q.aux_del_n) begin
                s_d.flags[3:1] = sel[3:1];
            end
            if (!carry_clock_delayed_n) begin
                s_d.flags[0] = sel[0];
            end
        end
        s_d.trace_pending = s_q.trace;

        // Register bus: answer one cycle after setup, zero wait after.
        if (apb_setup) begin
            s_d.apb_ready = 1'b1;
            s_d.apb_err = 1'b0;
            case (paddr)
                status_flag_pkg::STATUS_WORD_ADDR: begin
                    s_d.apb_rdata = {24'h00_0000, s_q.priority_lvl, s_q.trace, s_q.flags};
                end
                status_flag_pkg::TRACE_STATE_ADDR: begin
                    s_d.apb_rdata = {31'h0000_0000, s_q.trace_pending};
                end
                default: begin
                    s_d.apb_rdata = status_flag_pkg::READ_IDLE;
                    s_d.apb_err = 1'b1;
                end
            endcase
        end else if (apb_access) begin
            s_d.apb_ready = 1'b0;
            s_d.apb_err = 1'b0;
            s_d.apb_rdata = status_flag_pkg::READ_IDLE;
        end
        // A software write lands after any hardware load of the cycle.
        if (status_wr) begin
            s_d.priority_lvl = pwdata[7:5];
            s_d.trace = pwdata[4];
            s_d.flags = pwdata[3:0];
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
            s_q.aux_del_n <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign status_word = {s_q.priority_lvl, s_q.trace, s_q.flags};
    assign trace_pending_ff = s_q.trace_pending;
    assign prdata = s_q.apb_rdata;
    assign pready = s_q.apb_ready;
    assign pslverr = s_q.apb_err;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    chk_prio_load: assert property (
        !full_status_load_n && !status_wr
        |=> status_word[7:5] == $past(a_side_data[7:5]))
        else $error("priority field not loaded from multiplexer");

    chk_trace_pending: assert property (
        (!full_status_load_n && a_side_data[4] && !status_wr)
        |=> status_word[4] ##1 trace_pending_ff)
        else $error("trace bit or pending trace flag missing");

    chk_full_source: assert property (
        !full_status_load_n && !powerfail_init && s_q.aux_del_n && !status_wr
        |=> status_word[3:0] == $past(a_side_data[3:0]))
        else $error("full load did not take data bits 0 to 3");

    chk_init_blocks: assert property (
        powerfail_init && !full_status_load_n && !status_wr
        |=> status_word[3:0] == 4'h0)
        else $error("flag selector active during power-fail init");

    chk_neg_path: assert property (
        (next_negative && !aux_field_n)
        ##1 (!powerfail_init && full_status_load_n && !status_wr)
        |=> status_word[3])
        else $error("negative flag not set two cycles after cause");

    chk_zero_path: assert property (
        (!next_zero && !aux_field_n)
        ##1 (!powerfail_init && full_status_load_n && !status_wr)
        |=> !status_word[2])
        else $error("zero flag not cleared two cycles after cause");

    chk_rotate_carry: assert property (
        (rotate_instr_flag && rotate_carry_out && !aux_field_n)
        ##1 (!carry_clock_delayed_n && !powerfail_init
             && full_status_load_n && !status_wr)
        |=> status_word[0])
        else $error("rotate carry not loaded into carry flag");

    chk_shift_ovfl: assert property (
        (rotate_instr_flag && !aux_field_n)
        ##1 (!powerfail_init && full_status_load_n && !status_wr)
        |=> status_word[1] == (status_word[3] ^ $past(s_q.rot_c_del)))
        else $error("shift overflow is not negative xor carry");

    chk_table_carry: assert property (
        (!rotate_instr_flag && !aux_field_n)
        ##1 (!carry_clock_delayed_n && !powerfail_init
             && full_status_load_n && !status_wr)
        |=> status_word[0] == (status_flag_pkg::CV_TABLE[{$past(cv_table_in, 2), 1'b0}]
                               ^ $past(subtract_instr, 2)))
        else $error("table carry not delayed or modified correctly");

    chk_flags_hold: assert property (
        full_status_load_n && s_q.aux_del_n && carry_clock_delayed_n && !status_wr
        |=> $stable(status_word))
        else $error("status word changed without a load enable");

    chk_bus_answer: assert property (
        (psel && !penable) |=> pready ##1 !pready)
        else $error("register bus answer not one cycle wide");

    chk_bus_refuse: assert property (
        psel && !penable && paddr != status_flag_pkg::STATUS_WORD_ADDR
        && paddr != status_flag_pkg::TRACE_STATE_ADDR
        |=> pslverr && prdata == status_flag_pkg::READ_IDLE)
        else $error("unmapped register access not refused");

    chk_trace_delay: assert property (
        trace_pending_ff == $past(status_word[4]))
        else $error("pending trace flag does not follow trace bit");

endmodule : status_word_flag_logic

//--- design/status_flag_pkg.sv
package status_flag_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [31:0] STATUS_WORD_ADDR = 32'h0000_0000;
    localparam logic [31:0] TRACE_STATE_ADDR = 32'h0000_0004;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [31:0] READ_IDLE = 32'h0000_0000;

    // ------------------------------------------------------------
    // Status word field positions
    // ------------------------------------------------------------
    localparam int PRIO_MSB = 7;
    localparam int PRIO_LSB = 5;
    localparam int TRACE_BIT = 4;
    localparam int NEG_BIT = 3;
    localparam int ZERO_BIT = 2;
    localparam int OVFL_BIT = 1;
    localparam int CARRY_BIT = 0;

    // ------------------------------------------------------------
    // Zero detector masks
    // ------------------------------------------------------------
    localparam logic [15:0] BYTE_MASK = 16'h00FF;
    localparam logic [15:0] WORD_MASK = 16'hFFFF;
    localparam logic [15:0] ROT_BYTE_MASK = 16'h007E;
    localparam logic [15:0] ROT_WORD_MASK = 16'h7FFE;

    // ------------------------------------------------------------
    // Carry and overflow table
    // ------------------------------------------------------------
    // Two bits per entry: bit 1 overflow, bit 0 carry.
    localparam int CV_IN_W = 5;
    localparam logic [63:0] CV_TABLE = 64'hE4E4_E4E4_E4E4_E4E4;

    typedef enum logic [1:0] {
        SHIFT_ROTATE_RIGHT,
        SHIFT_ARITH_RIGHT,
        SHIFT_ROTATE_LEFT,
        SHIFT_ARITH_LEFT
    } shift_kind_t;

    function automatic logic zero_of(input logic [15:0] v, input logic [15:0] m);
        return ~|(v & m);
    endfunction : zero_of

    function automatic logic [1:0] cv_lookup(input logic [CV_IN_W-1:0] idx);
        return CV_TABLE[{idx, 1'b0} +: 2];
    endfunction : cv_lookup

endpackage : status_flag_pkg

//--- design/shift_flag_logic.sv
module shift_flag_logic (
    input wire logic [15:0] a_side_data,
    input wire logic [15:0] b_shift_register,
    input wire logic [15:0] b_operand_path,
    input wire logic left_shift_sign,
    input wire logic carry_flag,
    input wire logic byte_instr_flag,
    input wire logic rotate_instr_flag,
    input wire logic alu_select_hi_n,
    input wire logic alu_select_lo_n,
    output logic next_negative,
    output logic next_zero,
    output logic rotate_carry_out,
    output logic rotate_negative
);

    // ------------------------------------------------------------
    // Shift flag selector and negative/zero selector
    // ------------------------------------------------------------
    // The ALU select lines are reused here; microcode never drives the
    // ALU and these selectors in the same cycle.
    status_flag_pkg::shift_kind_t kind;
    logic zero_en;
    logic rot_zero;

    always_comb begin
        kind = status_flag_pkg::shift_kind_t'({~alu_select_hi_n, ~alu_select_lo_n});
        rotate_carry_out = b_shift_register[0];
        rotate_negative = b_shift_register[15];
        zero_en = 1'b0;
        case (kind)
            status_flag_pkg::SHIFT_ROTATE_RIGHT: begin
                rotate_carry_out = b_shift_register[0];
                rotate_negative = carry_flag;
                zero_en = ~b_shift_register[15] & ~carry_flag;
            end
            status_flag_pkg::SHIFT_ARITH_RIGHT: begin
                rotate_carry_out = b_shift_register[0];
                rotate_negative = b_shift_register[15];
                zero_en = ~b_operand_path[15];
            end
            status_flag_pkg::SHIFT_ROTATE_LEFT: begin
                rotate_carry_out = b_shift_register[15];
                rotate_negative = left_shift_sign;
                zero_en = ~b_shift_register[0] & ~carry_flag;
            end
            status_flag_pkg::SHIFT_ARITH_LEFT: begin
                rotate_carry_out = b_shift_register[15];
                rotate_negative = left_shift_sign;
                zero_en = ~b_operand_path[0];
            end
            default: begin
                zero_en = 1'b0;
            end
        endcase
        rot_zero = zero_en & status_flag_pkg::zero_of(b_operand_path,
            byte_instr_flag ? status_flag_pkg::ROT_BYTE_MASK
                            : status_flag_pkg::ROT_WORD_MASK);
        if (rotate_instr_flag) begin
            next_negative = rotate_negative;
            next_zero = rot_zero;
        end else if (byte_instr_flag) begin
            next_negative = a_side_data[7];
            next_zero = status_flag_pkg::zero_of(a_side_data,
                status_flag_pkg::BYTE_MASK);
        end else begin
            next_negative = a_side_data[15];
            next_zero = status_flag_pkg::zero_of(a_side_data,
                status_flag_pkg::WORD_MASK);
        end
    end

endmodule : shift_flag_logic

//--- testbench/datapath_model.sv
module datapath_model (
    input wire logic pclk,
    output logic [15:0] a_side_data,
    output logic [15:0] b_shift_register,
    output logic [15:0] b_operand_path,
    output logic left_shift_sign,
    output logic byte_instr_flag,
    output logic rotate_instr_flag,
    output logic alu_select_hi_n,
    output logic alu_select_lo_n,
    output logic aux_field_n,
    output logic full_status_load_n,
    output logic carry_clock_delayed_n,
    output logic powerfail_init,
    output logic subtract_instr,
    output logic [4:0] cv_table_in
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        {a_side_data, b_shift_register, b_operand_path, cv_table_in} = '0;
        {left_shift_sign, byte_instr_flag, rotate_instr_flag, subtract_instr} = '0;
        {alu_select_hi_n, alu_select_lo_n, aux_field_n, full_status_load_n} = '1;
        carry_clock_delayed_n = 1'b1;
        powerfail_init = 1'b0;
    end

    task automatic full_load(input logic [15:0] a, input logic init);
        a_side_data <= a;
        powerfail_init <= init;
        full_status_load_n <= 1'b0;
        @(posedge pclk);
        full_status_load_n <= 1'b1;
        powerfail_init <= 1'b0;
        @(posedge pclk);
    endtask : full_load

    // The shift kinds and the ALU share one select pair, never both in one op.
    // The data moves on after the first edge, so only a delayed copy can still be right.
    task automatic compute(input logic [15:0] a, bsr, bop, input logic [4:0] cv,
                           input logic [7:0] f);
        {a_side_data, b_shift_register, b_operand_path, cv_table_in} <= {a, bsr, bop, cv};
        {aux_field_n, byte_instr_flag, rotate_instr_flag} <= {~f[7], f[5], f[4]};
        {alu_select_hi_n, alu_select_lo_n, left_shift_sign, subtract_instr} <= {~f[3:2], f[1:0]};
        @(posedge pclk);
        aux_field_n <= 1'b1;
        carry_clock_delayed_n <= ~f[6];
        {a_side_data, b_shift_register, cv_table_in} <= ~{a, bsr, cv};
        {byte_instr_flag, rotate_instr_flag, left_shift_sign, subtract_instr} <= ~{f[5:4], f[1:0]};
        {alu_select_hi_n, alu_select_lo_n} <= f[3:2];
        @(posedge pclk);
        carry_clock_delayed_n <= 1'b1;
    endtask : compute
endmodule : datapath_model

//--- testbench/status_word_flag_logic_tb.sv
module status_word_flag_logic_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, trace_pending_ff;
    logic [31:0] paddr, pwdata, prdata;
    logic [15:0] a_side_data, b_shift_register, b_operand_path;
    logic left_shift_sign, byte_instr_flag, rotate_instr_flag, alu_select_hi_n;
    logic alu_select_lo_n, aux_field_n, full_status_load_n, carry_clock_delayed_n;
    logic powerfail_init, subtract_instr, tp_chk, tp_exp;
    logic [4:0] cv_table_in;
    logic [7:0] status_word, sw_exp, s;
    logic [33:0] apb_q[$];
    logic [33:0] e;
    logic [7:0] sw_q[$];
    int fail_count = 0;
    int total_checks = 0;
    int snap_n = 0;
    int snap_seen = 0;

    status_word_flag_logic u_status_word_flag_logic (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .a_side_data(a_side_data),
        .b_shift_register(b_shift_register), .b_operand_path(b_operand_path),
        .left_shift_sign(left_shift_sign), .byte_instr_flag(byte_instr_flag),
        .rotate_instr_flag(rotate_instr_flag), .alu_select_hi_n(alu_select_hi_n),
        .alu_select_lo_n(alu_select_lo_n), .aux_field_n(aux_field_n),
        .full_status_load_n(full_status_load_n), .carry_clock_delayed_n(carry_clock_delayed_n),
        .powerfail_init(powerfail_init), .subtract_instr(subtract_instr),
        .cv_table_in(cv_table_in), .status_word(status_word), .trace_pending_ff(trace_pending_ff));

    datapath_model u_datapath_model (.pclk(pclk), .a_side_data(a_side_data),
        .b_shift_register(b_shift_register), .b_operand_path(b_operand_path),
        .left_shift_sign(left_shift_sign), .byte_instr_flag(byte_instr_flag),
        .rotate_instr_flag(rotate_instr_flag), .alu_select_hi_n(alu_select_hi_n),
        .alu_select_lo_n(alu_select_lo_n), .aux_field_n(aux_field_n),
        .full_status_load_n(full_status_load_n), .carry_clock_delayed_n(carry_clock_delayed_n),
        .powerfail_init(powerfail_init), .subtract_instr(subtract_instr),
        .cv_table_in(cv_table_in));

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    // ------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic summarize();
        check(32'(apb_q.size()), 32'h0, "bus notes left");
        check(32'(sw_q.size()), 32'h0, "status notes left");
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : summarize

    initial begin
        repeat (20000) @(posedge pclk);
        fail_count++;
        summarize();
    end

    // ------------------------------------------------------------
    // Drivers and expectations
    // ------------------------------------------------------------
    task automatic apb(input logic wr, input logic [31:0] a, d, exp, input logic err, keep);
        apb_q.push_back({~wr, err, exp});
        {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 50 && pready !== 1'b1; i++) @(posedge pclk);
        check(32'(pready), 32'h1, "bus answer");
        penable <= 1'b0;
        if (!keep) psel <= 1'b0;
    endtask : apb

    task automatic expect_sw();
        sw_q.push_back(sw_exp);
        snap_n <= snap_n + 1;
    endtask : expect_sw

    function automatic logic [7:0] calc(input logic [7:0] p, input logic [15:0] a, bsr, bop,
                                        input logic [4:0] cv, input logic [7:0] f);
        logic rc, rz, n, z, c, v;
        rc = f[3] ? bsr[15] : bsr[0];
        rz = f[2] ? ~bop[f[3] ? 0 : 15] : ~bsr[f[3] ? 0 : 15] & ~p[0];
        n = f[4] ? (f[3] ? f[1] : (f[2] ? bsr[15] : p[0])) : (f[5] ? a[7] : a[15]);
        z = f[4] ? rz & ((bop & (f[5] ? 16'h007E : 16'h7FFE)) == 16'h0000)
                 : (f[5] ? a[7:0] == 8'h00 : a == 16'h0000);
        c = f[4] ? rc : status_flag_pkg::CV_TABLE[{cv, 1'b0}] ^ f[0];
        v = f[4] ? n ^ rc : status_flag_pkg::CV_TABLE[{cv, 1'b1}];
        if (!f[7]) {n, z, v, c} = {p[3:1], ~a[0]};
        return {p[7:4], n, z, v, f[6] ? c : p[0]};
    endfunction : calc

    // ------------------------------------------------------------
    // Output monitor
    // ------------------------------------------------------------
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1) begin
            e = apb_q.pop_front();
            check(32'(pslverr), 32'(e[32]), "bus error flag");
            if (e[33]) check(prdata, e[31:0], "bus read data");
        end
        if (tp_chk) check(32'(trace_pending_ff), 32'(tp_exp), "trace pending");
        if (snap_n != snap_seen) begin
            s = sw_q.pop_front();
            check(32'(status_word[7:5]), 32'(s[7:5]), "priority");
            check(32'(status_word[4]), 32'(s[4]), "trace");
            check(32'(status_word[3]), 32'(s[3]), "negative");
            check(32'(status_word[2]), 32'(s[2]), "zero");
            check(32'(status_word[1]), 32'(s[1]), "overflow");
            check(32'(status_word[0]), 32'(s[0]), "carry");
            tp_exp <= s[4];
            snap_seen <= snap_n;
        end
        tp_chk <= (snap_n != snap_seen);
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        logic [31:0] r;
        logic [15:0] a, b;
        logic [7:0] f;
        {presetn, psel, penable, pwrite, tp_chk, tp_exp} = '0;
        {paddr, pwdata} = '0;
        void'($urandom(32'h0000_0F75));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        sw_exp = status_flag_pkg::STATUS_RESET;
        expect_sw();
        r = $urandom;
        apb(1'b0, status_flag_pkg::STATUS_WORD_ADDR, 32'h0, 32'h0, 1'b0, 1'b1);
        apb(1'b1, status_flag_pkg::STATUS_WORD_ADDR, r | 32'h0000_0010, 32'h0, 1'b0, 1'b1);
        apb(1'b0, status_flag_pkg::STATUS_WORD_ADDR, 32'h0, {24'h0, r[7:5], 1'b1, r[3:0]}, 1'b0, 1'b1);
        apb(1'b0, 32'h0000_0008, 32'h0, 32'h0, 1'b1, 1'b1);
        apb(1'b1, 32'h0000_000C, 32'h0, 32'h0, 1'b1, 1'b1);
        apb(1'b0, status_flag_pkg::TRACE_STATE_ADDR, 32'h0, 32'h0000_0001, 1'b0, 1'b0);
        sw_exp = {r[7:5], 1'b1, r[3:0]};
        expect_sw();
        $display("test register access done");
        for (int i = 0; i < 8; i++) begin
            r = $urandom;
            u_datapath_model.full_load(r[15:0], r[16]);
            sw_exp = {r[7:4], r[16] ? 4'h0 : r[3:0]};
            expect_sw();
        end
        $display("test full load done");
        // The first eight passes walk every shift kind twice with both per-bit flag loads enabled.
        for (int i = 0; i < 40; i++) begin
            r = $urandom;
            a = $urandom;
            f = r[31:24];
            if (i < 8) f = {2'b11, f[5], 1'b1, i[1:0], f[1], 1'b0};
            else f[4] = 1'b0;
            b = f[4] ? r[23:8] & 16'h8181 : r[23:8];
            u_datapath_model.compute(a, r[15:0], b, r[4:0], f);
            sw_exp = calc(sw_exp, a, r[15:0], b, r[4:0], f);
            expect_sw();
        end
        $display("test flag compute done");
        repeat (2) @(posedge pclk);
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        sw_exp = status_flag_pkg::STATUS_RESET;
        expect_sw();
        repeat (4) @(posedge pclk);
        $display("test second reset done");
        summarize();
    end
endmodule : status_word_flag_logic_tb
